// ### verification/nvsrs_host.sv
// host model: one-cycle bus event strobes
// assumes framing is decoded elsewhere onto mclk
`timescale 1ns/1ps
module nvsrs_host (
  input  wire logic mclk,      // clock
  input  wire logic busy,      // lockout
  output logic      bus_start, // start
  output logic      bus_stop,  // stop
  output logic      wr_req,    // write
  output logic      rd_req,    // read
  output logic      cmd_valid, // command
  output logic      wake_req,  // wake
  output logic [2:0] cmd_code  // code
);
  logic [5:0] ev = 6'h00;
  logic [2:0] code = 3'h0;
  assign {wake_req, cmd_valid, rd_req, wr_req, bus_stop, bus_start} = ev;
  assign cmd_code = code;
  // held across exactly one sampling edge
  task automatic strobe(input logic [5:0] m, input logic [2:0] c);
    @(posedge mclk);
    #1 ev = m;
    code = c;
    @(posedge mclk);
    #1 ev = 6'h00;
    code = 3'h0;
  endtask
  // no service expected until lockout lifts
  task automatic wait_free(input int lim);
    repeat (lim) begin
      if (busy === 1'b1) begin
        @(posedge mclk);
        #1;
      end
    end
  endtask
endmodule

// ### verification/nvsrs_seq_checker.sv
// checker for the store/recall sequencer
// assumes one mclk domain, bound onto nvsrs_seq
`timescale 1ns/1ps
module nvsrs_seq_checker #(
  parameter int TIME_DIV = 1             // same divider as the sequencer
) (
  input wire logic       mclk,      // clock
  input wire logic       arst_n,    // reset
  input wire logic       vcc_ok,    // supply
  input wire logic       bus_stop,  // stop
  input wire logic       bus_start, // start
  input wire logic       cmd_valid, // cmd
  input wire logic [2:0] cmd_code,  // code
  input wire logic       wr_req,    // write
  input wire logic       rd_req,    // read
  input wire logic       wr_en,     // write ok
  input wire logic       rd_en,     // read ok
  input wire logic       busy,      // lockout
  input wire logic       store_go,  // save
  input wire logic       recall_go, // restore
  input wire logic       standby,   // standby
  input wire logic       sleeping,  // low power
  input wire logic       dirty      // written
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // limits follow the sequencer's divider
  localparam int SAVE_LIM = nvsrs_pkg::SAVE_CYC / TIME_DIV + 2;
  localparam int PUR_LIM  = nvsrs_pkg::RESTORE_PU_CYC / TIME_DIV + 2;
  localparam int SB_LIM   = nvsrs_pkg::STANDBY_CYC / TIME_DIV + 2;
  localparam int SEQ_LIM  = nvsrs_pkg::SEQ_CYC / TIME_DIV + 2;
  logic [19:0] c_reg [4];
  logic [19:0] c_next [4];
  logic        go_cmd;
  // run lengths; far too long for delay ranges
  always_comb begin
    go_cmd = cmd_valid && !busy && vcc_ok && cmd_code inside {3'h1, 3'h2};
    c_next[0] = store_go ? c_reg[0] + 20'h1 : 20'h0;
    c_next[1] = recall_go ? c_reg[1] + 20'h1 : 20'h0;
    c_next[2] = bus_stop ? 20'h1 : (c_reg[2] != 0 &&
                !(bus_start | wr_req | rd_req | cmd_valid | busy)) ? c_reg[2] + 20'h1 : 20'h0;
    c_next[3] = go_cmd ? 20'h1 : (c_reg[3] != 0 && !store_go && !recall_go && vcc_ok)
                ? c_reg[3] + 20'h1 : 20'h0;
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) c_reg <= '{default: 20'h0};
    else c_reg <= c_next;
  end
  property p_wr; wr_en |-> $past(wr_req); endproperty
  a_wr: assert property (p_wr) else $error("write without request");
  property p_rd; rd_en |-> $past(rd_req) && !$past(busy); endproperty
  a_rd: assert property (p_rd) else $error("read while locked");
  property p_lock; (store_go || recall_go) |-> busy && !rd_en; endproperty
  a_lock: assert property (p_lock) else $error("access during cycle");
  property p_dset; wr_en |-> dirty; endproperty
  a_dset: assert property (p_dset) else $error("flag not set");
  property p_dclr; ($fell(store_go) || $fell(recall_go)) && vcc_ok |-> !dirty; endproperty
  a_dclr: assert property (p_dclr) else $error("flag not cleared");
  property p_clean; $rose(store_go) && !vcc_ok |-> dirty; endproperty
  a_clean: assert property (p_clean) else $error("needless save");
  property p_loss; $fell(vcc_ok) |-> ##[1:4] busy; endproperty
  a_loss: assert property (p_loss) else $error("no lockout on loss");
  property p_save; c_reg[0] <= SAVE_LIM; endproperty
  a_save: assert property (p_save) else $error("save too long");
  property p_pur; c_reg[1] <= PUR_LIM; endproperty
  a_pur: assert property (p_pur) else $error("restore too long");
  property p_sb; c_reg[2] > SB_LIM |-> standby; endproperty
  a_sb: assert property (p_sb) else $error("standby late");
  property p_seq; c_reg[3] <= SEQ_LIM; endproperty
  a_seq: assert property (p_seq) else $error("command late");
  property p_slp; sleeping |-> busy && !rd_en && !wr_en; endproperty
  a_slp: assert property (p_slp) else $error("access while asleep");
  c_save: cover property ($rose(store_go));
  c_rest: cover property ($rose(recall_go));
  c_sb: cover property ($rose(standby));
  c_slp: cover property ($rose(sleeping));
endmodule
bind nvsrs_seq nvsrs_seq_checker #(.TIME_DIV(TIME_DIV)) nvsrs_seq_checker_i (.mclk, .arst_n,
  .vcc_ok, .bus_stop, .bus_start, .cmd_valid, .cmd_code, .wr_req, .rd_req, .wr_en, .rd_en,
  .busy, .store_go, .recall_go, .standby, .sleeping, .dirty);

// ### verification/tb_top.sv
// testbench for the store/recall sequencer
// assumes the host model raises all bus events
`timescale 1ns/1ps
module tb_top;
  logic mclk, arst_n, vcc_ok, bus_stop, bus_start, cmd_valid, wake_req, wr_req, rd_req;
  logic [2:0] cmd_code;
  logic wr_en, rd_en, busy, store_go, recall_go, sleeping, standby, dirty;
  int err_total, compares, n;
  // long intervals shortened so the run stays short; their ratios are kept
  localparam int TDIV = 100;
  nvsrs_seq #(.TIME_DIV(TDIV)) nvsrs_seq_i (.mclk, .arst_n, .vcc_ok, .bus_stop, .bus_start,
    .cmd_valid,
    .cmd_code, .wake_req, .wr_req, .rd_req, .wr_en, .rd_en, .busy, .store_go, .recall_go,
    .sleeping, .standby, .dirty);
  nvsrs_host nvsrs_host_i (.mclk, .busy, .bus_start, .bus_stop, .wr_req, .rd_req,
    .cmd_valid, .wake_req, .cmd_code);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_max(input string nm, input int e, input int g);
    compares++;
    if (g > e) begin
      err_total++;
      $display("[FAIL] %s expected <=%0d seen %0d", nm, e, g);
    end
  endtask
  // level watched by span: busy, restoring, not restoring, saving, not saving, awake
  function automatic logic lvl(input int s);
    case (s)
      0: lvl = busy;
      1: lvl = recall_go;
      2: lvl = !recall_go;
      3: lvl = store_go;
      4: lvl = !store_go;
      default: lvl = !sleeping;
    endcase
  endfunction
  // cycles while the watched level stays high
  task automatic span(input int s, output int k);
    k = 0;
    while (k < 20000 && lvl(s) === 1'b1) begin
      @(posedge mclk);
      #1 k++;
    end
  endtask
  task automatic t_powerup;
    nvsrs_host_i.strobe(6'h08, 3'h0);
    chk("rd_en", 1'b0, rd_en);
    span(0, n);
    chk_max("pu_restore", nvsrs_pkg::RESTORE_PU_CYC / TDIV + 4, n);
    chk("dirty", 1'b0, dirty);
    $display("test powerup done");
  endtask
  task automatic t_access;
    nvsrs_host_i.strobe(6'h04, 3'h0);
    chk("wr_en", 1'b1, wr_en);
    chk("dirty", 1'b1, dirty);
    nvsrs_host_i.strobe(6'h08, 3'h0);
    chk("rd_en", 1'b1, rd_en);
    $display("test access done");
  endtask
  task automatic t_standby;
    nvsrs_host_i.strobe(6'h02, 3'h0);
    repeat (nvsrs_pkg::STANDBY_CYC / TDIV + 3) @(posedge mclk);
    #1 chk("standby", 1'b1, standby);
    nvsrs_host_i.strobe(6'h04, 3'h0);
    chk("wr_en", 1'b1, wr_en);
    chk("standby", 1'b0, standby);
    $display("test standby done");
  endtask
  task automatic t_restore;
    nvsrs_host_i.strobe(6'h10, nvsrs_pkg::CMD_RESTORE);
    span(2, n);
    chk_max("seq", nvsrs_pkg::SEQ_CYC / TDIV + 2, n);
    nvsrs_host_i.strobe(6'h08, 3'h0);
    chk("rd_en", 1'b0, rd_en);
    span(1, n);
    chk_max("restore", nvsrs_pkg::RESTORE_SW_CYC / TDIV + 2, n);
    chk("dirty", 1'b0, dirty);
    nvsrs_host_i.wait_free(8);
    $display("test restore done");
  endtask
  // software save after a write; the flag must clear at the end
  task automatic t_save;
    nvsrs_host_i.strobe(6'h04, 3'h0);
    nvsrs_host_i.strobe(6'h10, nvsrs_pkg::CMD_SAVE);
    span(4, n);
    chk_max("save_seq", nvsrs_pkg::SEQ_CYC / TDIV + 2, n);
    chk("busy", 1'b1, busy);
    span(3, n);
    chk_max("save", nvsrs_pkg::SAVE_CYC / TDIV + 2, n);
    chk("dirty", 1'b0, dirty);
    $display("test save done");
  endtask
  // sleep limit counts from the command; wake must not wait past its limit
  task automatic t_sleep;
    nvsrs_host_i.strobe(6'h10, nvsrs_pkg::CMD_SLEEP);
    span(5, n);
    chk_max("sleep", nvsrs_pkg::SLEEP_CYC / TDIV, n);
    nvsrs_host_i.strobe(6'h08, 3'h0);
    chk("rd_en", 1'b0, rd_en);
    nvsrs_host_i.strobe(6'h20, 3'h0);
    chk("sleeping", 1'b0, sleeping);
    nvsrs_host_i.wait_free(nvsrs_pkg::WAKE_CYC / TDIV + 2);
    chk("busy", 1'b0, busy);
    $display("test sleep done");
  endtask
  // a save follows supply loss only after a write
  task automatic t_loss(input logic wrote);
    vcc_ok = 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk("busy", 1'b1, busy);
    chk("store_go", wrote, store_go);
    $display("test loss done");
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // two power-up restores and the wake dominate; about 20000 cycles expected
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    complete_run;
  end
  initial begin
    arst_n = 1'b0;
    vcc_ok = 1'b1;
    repeat (6) @(posedge mclk);
    #1 arst_n = 1'b1;
    t_powerup;
    t_access;
    t_standby;
    t_restore;
    t_save;
    t_sleep;
    t_loss(1'b0);
    vcc_ok = 1'b1;
    t_powerup;
    t_access;
    t_loss(1'b1);
    complete_run;
  end
endmodule

// ### verilog/nvsrs_pkg.sv
// constants for the store/recall sequencer of a serial nonvolatile sram
// assumes a single 25 mhz timebase; all times rounded to whole cycles
package nvsrs_pkg;
  localparam int CLK_HZ           = 25000000;
  localparam int RESTORE_PU_MS    = 20;
  localparam int SAVE_MS          = 8;
  localparam int WRITE_GRACE_NS   = 25;
  localparam int SLEEP_MS         = 8;
  localparam int WAKE_MS          = 20;
  localparam int STANDBY_US       = 100;
  localparam int SEQ_US           = 500;
  localparam int RESTORE_SW_US    = 600;
  // the write grace time rounds down, never below one cycle
  localparam int RESTORE_PU_CYC   = RESTORE_PU_MS * (CLK_HZ / 1000);
  localparam int SAVE_CYC         = SAVE_MS * (CLK_HZ / 1000);
  localparam int SLEEP_CYC        = SLEEP_MS * (CLK_HZ / 1000);
  localparam int WAKE_CYC         = WAKE_MS * (CLK_HZ / 1000);
  localparam int STANDBY_CYC      = STANDBY_US * (CLK_HZ / 1000000);
  localparam int SEQ_CYC          = SEQ_US * (CLK_HZ / 1000000);
  localparam int RESTORE_SW_CYC   = RESTORE_SW_US * (CLK_HZ / 1000000);
  localparam int GRACE_RAW        = (WRITE_GRACE_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int WRITE_GRACE_CYC  = (GRACE_RAW < 1) ? 1 : GRACE_RAW;
  localparam int CNT_W            = 20;
  localparam logic [2:0] CMD_NONE    = 3'h0;
  localparam logic [2:0] CMD_SAVE    = 3'h1;
  localparam logic [2:0] CMD_RESTORE = 3'h2;
  localparam logic [2:0] CMD_SLEEP   = 3'h3;
  typedef enum logic [3:0] {
    ST_PU_RESTORE = 4'h0,
    ST_ACTIVE     = 4'h1,
    ST_STANDBY    = 4'h2,
    ST_SEQ_WAIT   = 4'h3,
    ST_SAVE       = 4'h4,
    ST_RESTORE    = 4'h5,
    ST_SLEEP_ENT  = 4'h6,
    ST_SLEEP      = 4'h7,
    ST_WAKE       = 4'h8,
    ST_PL_GRACE   = 4'h9,
    ST_PL_SAVE    = 4'ha,
    ST_DEAD       = 4'hb
  } nvsrs_state_t;
endpackage

// ### verilog/nvsrs_seq.sv
// store/recall sequencer: power-up restore, power-loss save, software
// save/restore, sleep/wake and standby; gates reads while busy, and writes except in the grace window.
// assumes vcc_ok is a raw pin, synchronised here; bus event strobes come
// from the i2c engine on mclk.
`timescale 1ns/1ps
module nvsrs_seq #(
  parameter int TIME_DIV = 1             // divides every timed interval; 1 keeps real timing
) (
  input  wire logic        mclk,          // 25 mhz timebase
  input  wire logic        arst_n,        // power-on reset, active low
  input  wire logic        vcc_ok,        // supply above trigger level (pin)
  input  wire logic        bus_stop,      // stop condition seen, pulse
  input  wire logic        bus_start,     // start condition seen, pulse
  input  wire logic        cmd_valid,     // sequence command accepted, pulse
  input  wire logic [2:0]  cmd_code,      // command code with cmd_valid
  input  wire logic        wake_req,      // wake request, pulse
  input  wire logic        wr_req,        // array write cycle, pulse
  input  wire logic        rd_req,        // array read cycle, pulse
  output logic             wr_en,         // write accepted this cycle
  output logic             rd_en,         // read accepted this cycle
  output logic             busy,          // access locked out
  output logic             store_go,      // nonvolatile save running
  output logic             recall_go,     // nonvolatile restore running
  output logic             sleeping,      // low-power state reached
  output logic             standby,       // standby state reached
  output logic             dirty          // array written since last cycle
);
  nvsrs_pkg::nvsrs_state_t state_reg, state_next;
  logic [nvsrs_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0] cmd_reg, cmd_next;
  logic dirty_reg, dirty_next;
  logic vs1_reg, vs2_reg;
  logic wr_en_reg, rd_en_reg, busy_reg, st_reg, rc_reg, sl_reg, sb_reg;
  logic wr_en_next, rd_en_next, busy_next, st_next, rc_next, sl_next, sb_next;
  logic open_st;

  // cycle count for a duration, as counter width
  function automatic logic [nvsrs_pkg::CNT_W-1:0] cyc(input int n);
    int m;
    m   = n / TIME_DIV;
    // never below one cycle, so the grace window survives any divider
    cyc = nvsrs_pkg::CNT_W'((m < 1) ? 0 : m - 1);
  endfunction

  // two-flop synchroniser on the supply pin
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      vs1_reg <= 1'b0;
      vs2_reg <= 1'b0;
    end else begin
      vs1_reg <= vcc_ok;
      vs2_reg <= vs1_reg;
    end
  end

  // array is open only in active or standby with a good supply
  assign open_st = vs2_reg &&
                   (state_reg == nvsrs_pkg::ST_ACTIVE || state_reg == nvsrs_pkg::ST_STANDBY);

  // next-state logic for sequencer, flags and outputs
  always_comb begin
    state_next = state_reg;
    cnt_next   = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    cmd_next   = cmd_reg;
    dirty_next = dirty_reg;
    wr_en_next = 1'b0;
    rd_en_next = 1'b0;
    case (state_reg)
      nvsrs_pkg::ST_PU_RESTORE: begin
        // restore starts once supply is good; finishes at count end
        if (!vs2_reg) begin
          cnt_next = cyc(nvsrs_pkg::RESTORE_PU_CYC);
        end else if (cnt_reg == '0) begin
          state_next = nvsrs_pkg::ST_ACTIVE;
          dirty_next = 1'b0;
        end
      end
      nvsrs_pkg::ST_ACTIVE, nvsrs_pkg::ST_STANDBY: begin
        wr_en_next = wr_req && vs2_reg;
        rd_en_next = rd_req && vs2_reg;
        if (wr_req && vs2_reg) begin
          dirty_next = 1'b1;
        end
        if (bus_start || wr_req || rd_req) begin
          state_next = nvsrs_pkg::ST_ACTIVE;
        end
        if (bus_stop && state_reg == nvsrs_pkg::ST_ACTIVE) begin
          cnt_next = cyc(nvsrs_pkg::STANDBY_CYC);
        end else if (state_reg == nvsrs_pkg::ST_ACTIVE && cnt_reg == 1 && !bus_start) begin
          state_next = nvsrs_pkg::ST_STANDBY;
        end
        if (cmd_valid && cmd_code != nvsrs_pkg::CMD_NONE) begin
          state_next = nvsrs_pkg::ST_SEQ_WAIT;
          cmd_next   = cmd_code;
          cnt_next   = cyc(nvsrs_pkg::SEQ_CYC);
        end
        if (!vs2_reg) begin
          state_next = nvsrs_pkg::ST_PL_GRACE;
          cnt_next   = cyc(nvsrs_pkg::WRITE_GRACE_CYC);
        end
      end
      nvsrs_pkg::ST_SEQ_WAIT: begin
        // act on the command no later than the processing limit
        if (cnt_reg == '0) begin
          case (cmd_reg)
            nvsrs_pkg::CMD_SAVE: begin
              state_next = nvsrs_pkg::ST_SAVE;
              cnt_next   = cyc(nvsrs_pkg::SAVE_CYC);
            end
            nvsrs_pkg::CMD_RESTORE: begin
              state_next = nvsrs_pkg::ST_RESTORE;
              cnt_next   = cyc(nvsrs_pkg::RESTORE_SW_CYC);
            end
            nvsrs_pkg::CMD_SLEEP: begin
              // the processing wait already counts toward the sleep limit
              state_next = nvsrs_pkg::ST_SLEEP_ENT;
              cnt_next   = cyc(nvsrs_pkg::SLEEP_CYC - nvsrs_pkg::SEQ_CYC);
            end
            default: state_next = nvsrs_pkg::ST_ACTIVE;
          endcase
        end
      end
      nvsrs_pkg::ST_SAVE, nvsrs_pkg::ST_RESTORE: begin
        if (cnt_reg == '0) begin
          state_next = nvsrs_pkg::ST_ACTIVE;
          dirty_next = 1'b0;
        end
      end
      nvsrs_pkg::ST_SLEEP_ENT: begin
        if (cnt_reg == '0) begin
          state_next = nvsrs_pkg::ST_SLEEP;
        end
      end
      nvsrs_pkg::ST_SLEEP: begin
        if (wake_req) begin
          state_next = nvsrs_pkg::ST_WAKE;
          cnt_next   = cyc(nvsrs_pkg::WAKE_CYC);
        end
      end
      nvsrs_pkg::ST_WAKE: begin
        if (cnt_reg == '0) begin
          state_next = nvsrs_pkg::ST_ACTIVE;
        end
      end
      nvsrs_pkg::ST_PL_GRACE: begin
        // a write already in flight may still land during the grace window
        wr_en_next = wr_req;
        if (wr_req) begin
          dirty_next = 1'b1;
        end
        if (cnt_reg == '0) begin
          if (dirty_next) begin
            state_next = nvsrs_pkg::ST_PL_SAVE;
            cnt_next   = cyc(nvsrs_pkg::SAVE_CYC);
          end else begin
            state_next = nvsrs_pkg::ST_DEAD;
          end
        end
      end
      nvsrs_pkg::ST_PL_SAVE: begin
        if (cnt_reg == '0) begin
          state_next = nvsrs_pkg::ST_DEAD;
          dirty_next = 1'b0;
        end
      end
      nvsrs_pkg::ST_DEAD: begin
        // wait for supply to return, then restore again
        if (vs2_reg) begin
          state_next = nvsrs_pkg::ST_PU_RESTORE;
          cnt_next   = cyc(nvsrs_pkg::RESTORE_PU_CYC);
        end
      end
      default: state_next = nvsrs_pkg::ST_PU_RESTORE;
    endcase
    // supply loss in a software restore, sleep entry or wake falls to dead state
    if (!vs2_reg && (state_next == nvsrs_pkg::ST_RESTORE ||
                     state_next == nvsrs_pkg::ST_SLEEP_ENT ||
                     state_next == nvsrs_pkg::ST_WAKE)) begin
      state_next = nvsrs_pkg::ST_DEAD;
    end
    // a command still waiting leaves written data unsaved: take the loss path
    if (!vs2_reg && state_next == nvsrs_pkg::ST_SEQ_WAIT) begin
      state_next = nvsrs_pkg::ST_PL_GRACE;
      cnt_next   = cyc(nvsrs_pkg::WRITE_GRACE_CYC);
    end
    busy_next = !(state_next == nvsrs_pkg::ST_ACTIVE ||
                  state_next == nvsrs_pkg::ST_STANDBY) || !vs2_reg;
    st_next   = (state_next == nvsrs_pkg::ST_SAVE || state_next == nvsrs_pkg::ST_PL_SAVE);
    rc_next   = (state_next == nvsrs_pkg::ST_RESTORE ||
                 (state_next == nvsrs_pkg::ST_PU_RESTORE && vs2_reg));
    sl_next   = (state_next == nvsrs_pkg::ST_SLEEP);
    sb_next   = (state_next == nvsrs_pkg::ST_STANDBY);
  end

  // register all state and outputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= nvsrs_pkg::ST_PU_RESTORE;
      cnt_reg   <= '0;
      cmd_reg   <= nvsrs_pkg::CMD_NONE;
      dirty_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      busy_reg  <= 1'b1;
      st_reg    <= 1'b0;
      rc_reg    <= 1'b0;
      sl_reg    <= 1'b0;
      sb_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cmd_reg   <= cmd_next;
      dirty_reg <= dirty_next;
      wr_en_reg <= wr_en_next;
      rd_en_reg <= rd_en_next;
      busy_reg  <= busy_next;
      st_reg    <= st_next;
      rc_reg    <= rc_next;
      sl_reg    <= sl_next;
      sb_reg    <= sb_next;
    end
  end

  assign wr_en     = wr_en_reg;
  assign rd_en     = rd_en_reg;
  assign busy      = busy_reg;
  assign store_go  = st_reg;
  assign recall_go = rc_reg;
  assign sleeping  = sl_reg;
  assign standby   = sb_reg;
  assign dirty     = dirty_reg;
endmodule
